// ### inc/awc_regs.svh
`ifndef AWC_REGS_SVH
`define AWC_REGS_SVH
// Register indices; byte address is four times the index
`define AWC_CFG_IDX    6'h01
`define AWC_STAT_IDX   6'h02
// Wait-state control reset value and the usual setting
`define AWC_CFG_RST    8'hc0
`define AWC_CFG_TYP    8'h00
// Wait-state control field positions
`define AWC_IOW_HI     7
`define AWC_IOW_LO     6
`define AWC_D8_HI      5
`define AWC_D8_LO      4
`define AWC_D16_HI     3
`define AWC_D16_LO     2
`define AWC_MRD_BIT    1
`define AWC_CLK_BIT    0
// Status bit positions
`define AWC_ST_IO      0
`define AWC_ST_DMA     1
`define AWC_ST_RDY     2
// Bus transfer size accepted
`define AWC_HSIZE_WORD 3'h2
// Port decoded outside the peripheral core
`define AWC_PORT_SKIP  10'h070
`endif

// ### inc/awc_pkg.sv
package awc_pkg;
  // Two-bit wait code of a field
  typedef logic [1:0] awc_code_t;
  // DMA command sequencer states
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_LEAD = 3'b010,
    DMA_CMD  = 3'b100
  } awc_dma_st_t;

  // Core I/O wait code to bus clocks: 0, 1, 2, 4
  // codes 10, 11: two, four
  function automatic logic [2:0] ioWaits(input awc_code_t c);
    ioWaits = (c == 2'h3) ? 3'h4 : {1'b0, c};
  endfunction

  // DMA wait code to DMA clocks: 1 to 4
  // codes give one to four
  function automatic logic [2:0] dmaWaits(input awc_code_t c);
    dmaWaits = {1'b0, c} + 3'h1;
  endfunction

  // Port served by the integrated peripheral core
  function automatic logic ipcPort(input logic [9:0] a);
    ipcPort = (a[9:8] == 2'h0) &&
      ((a[7:4] == 4'h0) || (a[7:2] == 6'h08) || (a[7:2] == 6'h10) ||
       (a[7:0] == 8'h71) || (a[7:4] == 4'h8) || (a[7:1] == 7'h50) ||
       (a[7:5] == 3'h6));
  endfunction
endpackage

// ### inc/awc_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// Settings out to the timers, busy flags back
interface awc_cfg_if;
  import awc_pkg::*;
  awc_code_t ioWait;       // Core I/O wait code
  awc_code_t dma8Wait;     // 8-bit DMA wait code
  awc_code_t dma16Wait;    // 16-bit DMA wait code
  logic      memRdNoDelay; // Memory read starts with the cycle
  logic      dmaFast;      // DMA clock equals bus clock
  logic      ioBusy;       // Ready is being held low
  logic      dmaBusy;      // DMA command in progress
  modport ctl (output ioWait, dma8Wait, dma16Wait, memRdNoDelay, dmaFast,
               input ioBusy, dmaBusy);
  modport io  (input ioWait, output ioBusy);
  modport dma (input dma8Wait, dma16Wait, memRdNoDelay, dmaFast,
               output dmaBusy);
endinterface
`default_nettype wire

// ### rtl/awc_io_wait.sv
`timescale 1ns/1ps
`default_nettype none
// Holds ready low on core port accesses
module awc_io_wait
  import awc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  awc_cfg_if.io           cfg,
  input  wire logic       ioStart,
  input  wire logic [9:0] portAddr,
  output logic            ioChRdyOeN
);
  logic [2:0] waitCnt; // Bus clocks of wait still to insert

  // Wait counter; a new cycle cannot start while ready is low
  always_ff @(posedge clk) begin
    if (rst) begin
      waitCnt    <= 3'h0;
      ioChRdyOeN <= 1'b1;
    end else if (waitCnt == 3'h0) begin
      if (ioStart && ipcPort(portAddr) && ioWaits(cfg.ioWait) != 3'h0) begin
        waitCnt    <= ioWaits(cfg.ioWait);
        ioChRdyOeN <= 1'b0;
      end
    end else begin
      waitCnt    <= waitCnt - 3'h1;
      ioChRdyOeN <= (waitCnt == 3'h1);
    end
  end

  assign cfg.ioBusy = (waitCnt != 3'h0);
endmodule
`default_nettype wire

// ### rtl/awc_dma_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Shapes DMA command strobes in DMA clock periods
module awc_dma_timer
  import awc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  awc_cfg_if.dma    cfg,
  input  wire logic dmaStart,
  input  wire logic dmaWide,
  input  wire logic dmaToMem,
  input  wire logic rdyIn,
  output logic      ioRdN,
  output logic      ioWrN,
  output logic      memRdN,
  output logic      memWrN,
  output logic      dmaDone
);
  awc_dma_st_t st;      // Sequencer state
  logic [2:0]  cnt;     // DMA clocks left of command low time
  logic        half;    // Odd bus clock of a slow DMA clock
  logic        tick;    // End of one DMA clock period

  // DMA clock is one or two bus clocks
  assign tick = cfg.dmaFast | half;

  // Divider restarts with each cycle so the low time is exact
  always_ff @(posedge clk) begin
    if (rst || st == DMA_IDLE) begin
      half <= 1'b0;
    end else begin
      half <= ~half;
    end
  end

  // Command sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st      <= DMA_IDLE;
      cnt     <= 3'h0;
      ioRdN   <= 1'b1;
      ioWrN   <= 1'b1;
      memRdN  <= 1'b1;
      memWrN  <= 1'b1;
      dmaDone <= 1'b0;
    end else begin
      dmaDone <= 1'b0;
      unique case (st)
        DMA_IDLE: begin
          if (dmaStart) begin
            cnt    <= dmaWaits(dmaWide ? cfg.dma16Wait : cfg.dma8Wait) + 3'h1;
            ioRdN  <= ~dmaToMem;
            memWrN <= ~dmaToMem;
            ioWrN  <= dmaToMem;
            // memory read may lag one period
            memRdN <= dmaToMem | ~cfg.memRdNoDelay;
            st     <= (!dmaToMem && !cfg.memRdNoDelay) ? DMA_LEAD : DMA_CMD;
          end
        end
        DMA_LEAD: begin
          if (tick) begin
            memRdN <= 1'b0;
            cnt    <= cnt - 3'h1;
            st     <= DMA_CMD;
          end
        end
        DMA_CMD: begin
          if (tick) begin
            if (cnt != 3'h1) begin
              cnt <= cnt - 3'h1;
            end else if (rdyIn) begin
              ioRdN   <= 1'b1;
              ioWrN   <= 1'b1;
              memRdN  <= 1'b1;
              memWrN  <= 1'b1;
              dmaDone <= 1'b1;
              st      <= DMA_IDLE;
            end
          end
        end
        default: st <= DMA_IDLE;
      endcase
    end
  end

  assign cfg.dmaBusy = (st != DMA_IDLE);
endmodule
`default_nettype wire

// ### rtl/awc_top.sv
// Functional notes
// - Register resets to C0h; usually 00h
// - Bits 7:6 add core I/O wait clocks
// - Core wait only on listed port ranges
// - Port 70h gets no core wait
// - Waits inserted by holding ready low
// - Core code 10 two, 11 four
// - Bits 5:4, 3:2 are DMA wait fields
// - DMA codes give one to four waits
// - DMA waits lengthen write command low time
// - One wait gives two-period command low
// - Bit 1 clear delays memory read one period
// - Bit 0 picks DMA clock period
`timescale 1ns/1ps
`default_nettype none
`include "awc_regs.svh"
// AT bus wait control: AHB-Lite slave, pin syncs, I/O and DMA timers
module awc_top
  import awc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        ioCmdN,
  input  wire logic [9:0]  portAddr,
  input  wire logic        dmaReq,
  input  wire logic        dmaWide,
  input  wire logic        dmaToMem,
  input  wire logic        ioChRdyIn,
  output logic             ioChRdyOut,
  output logic             ioChRdyOeN,
  output logic             dmaIoRdN,
  output logic             dmaIoWrN,
  output logic             dmaMemRdN,
  output logic             dmaMemWrN,
  output logic             dmaDone
);
  // Pin synchronisers
  logic [14:0] pinMeta;    // First stage, read only by pinSync
  logic [14:0] pinSync;    // Second stage, safe to use
  logic        ioCmdS;     // I/O command, active low
  logic [9:0]  addrS;      // Port address
  logic        dmaReqS;    // DMA cycle request
  logic        wideS;      // 16-bit DMA transfer
  logic        toMemS;     // DMA writes memory
  logic        rdyS;       // Ready wire level
  logic        ioCmdPrevN; // Last command level
  logic        dmaReqPrev; // Last request level
  logic        ioStart;    // I/O command fell
  logic        dmaStart;   // DMA request rose

  // Bus slave state
  logic [7:0]  cfgReg;     // Wait-state control register
  logic        wrPendReg;  // Write data phase pending
  logic        addrOk;     // Valid word transfer offered
  logic [31:0] readMux;    // Read data of the address phase

  awc_cfg_if cfgIf ();

  // True when the byte address selects register idx
  function automatic logic hitIdx(input logic [7:0] a, input logic [5:0] idx);
    hitIdx = (a[7:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // Two flops on every pin; address settles before command
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta <= 15'h7ff1;
      pinSync <= 15'h7ff1;
    end else begin
      pinMeta <= {ioCmdN, portAddr, dmaReq, dmaWide, dmaToMem, ioChRdyIn};
      pinSync <= pinMeta;
    end
  end

  assign ioCmdS  = pinSync[14];
  assign addrS   = pinSync[13:4];
  assign dmaReqS = pinSync[3];
  assign wideS   = pinSync[2];
  assign toMemS  = pinSync[1];
  assign rdyS    = pinSync[0];

  // Edge detectors work on synchronised levels only
  always_ff @(posedge clk) begin
    if (rst) begin
      ioCmdPrevN <= 1'b1;
      dmaReqPrev <= 1'b0;
    end else begin
      ioCmdPrevN <= ioCmdS;
      dmaReqPrev <= dmaReqS;
    end
  end

  assign ioStart  = ioCmdPrevN & ~ioCmdS;
  assign dmaStart = dmaReqS & ~dmaReqPrev;

  // Only whole-word transfers, NONSEQ or SEQ, are accepted
  assign addrOk = hsel & hready & htrans[1] & (hsize == `AWC_HSIZE_WORD);

  // Read mux; unmapped words read zero
  always_comb begin
    readMux = 32'h0;
    if (hitIdx(haddr[7:0], `AWC_CFG_IDX)) begin
      readMux[7:0] = cfgReg;
    end else if (hitIdx(haddr[7:0], `AWC_STAT_IDX)) begin
      readMux[`AWC_ST_IO]  = cfgIf.ioBusy;
      readMux[`AWC_ST_DMA] = cfgIf.dmaBusy;
      readMux[`AWC_ST_RDY] = rdyS;
    end
  end

  // Zero-wait slave; response is always OKAY
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPendReg <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPendReg <= addrOk & hwrite & hitIdx(haddr[7:0], `AWC_CFG_IDX);
      // Data is fetched in the address phase, shown in the data phase
      if (addrOk & ~hwrite) begin
        hrdata <= readMux;
      end
    end
  end

  // Control register, written in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgReg <= `AWC_CFG_RST;
    end else if (wrPendReg) begin
      cfgReg <= hwdata[7:0];
    end
  end

  // Fields to the timers; settings other than the DMA clock select are taken at each cycle start
  assign cfgIf.ioWait       = cfgReg[`AWC_IOW_HI:`AWC_IOW_LO];
  assign cfgIf.dma8Wait     = cfgReg[`AWC_D8_HI:`AWC_D8_LO];
  assign cfgIf.dma16Wait    = cfgReg[`AWC_D16_HI:`AWC_D16_LO];
  assign cfgIf.memRdNoDelay = cfgReg[`AWC_MRD_BIT];
  assign cfgIf.dmaFast      = cfgReg[`AWC_CLK_BIT];

  // Ready is open drain: the driven level is always low
  always_ff @(posedge clk) begin
    ioChRdyOut <= 1'b0;
  end

  // Core I/O wait timer
  awc_io_wait u_io (
    .clk        (clk),
    .rst        (rst),
    .cfg        (cfgIf.io),
    .ioStart    (ioStart),
    .portAddr   (addrS),
    .ioChRdyOeN (ioChRdyOeN)
  );

  // DMA command timer; ready seen here may be pulled by anyone
  awc_dma_timer u_dma (
    .clk      (clk),
    .rst      (rst),
    .cfg      (cfgIf.dma),
    .dmaStart (dmaStart),
    .dmaWide  (wideS),
    .dmaToMem (toMemS),
    .rdyIn    (rdyS),
    .ioRdN    (dmaIoRdN),
    .ioWrN    (dmaIoWrN),
    .memRdN   (dmaMemRdN),
    .memWrN   (dmaMemWrN),
    .dmaDone  (dmaDone)
  );

  // Checks on the behaviour seen at the pins
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic ioIdle;  // No wait in progress
  logic dmaGo;   // DMA cycle accepted this clock
  assign ioIdle = ioChRdyOeN;
  assign dmaGo  = dmaStart & ~cfgIf.dmaBusy;

  rst_value_a: assert property (disable iff (1'b0)
    rst |=> cfgReg == `AWC_CFG_RST)
    else $error("control register not C0h after reset");

  io_wait_four_a: assert property (
    ioStart && ioIdle && ipcPort(addrS) && cfgReg[7:6] == 2'h3
    |=> !ioChRdyOeN [*4] ##1 ioChRdyOeN)
    else $error("code 11 did not hold ready four clocks");

  io_wait_two_a: assert property (
    ioStart && ioIdle && ipcPort(addrS) && cfgReg[7:6] == 2'h2
    |=> !ioChRdyOeN [*2] ##1 ioChRdyOeN)
    else $error("code 10 did not hold ready two clocks");

  io_wait_one_a: assert property (
    ioStart && ioIdle && ipcPort(addrS) && cfgReg[7:6] == 2'h1
    |=> !ioChRdyOeN ##1 ioChRdyOeN)
    else $error("code 01 did not hold ready one clock");

  io_wait_none_a: assert property (
    ioStart && ioIdle && cfgReg[7:6] == 2'h0 |=> ioChRdyOeN)
    else $error("code 00 pulled ready");

  io_range_a: assert property (
    ioStart && ioIdle && !ipcPort(addrS) |=> ioChRdyOeN)
    else $error("ready pulled on a port outside the core");

  port_skip_a: assert property (
    ioStart && ioIdle && addrS == `AWC_PORT_SKIP |=> ioChRdyOeN)
    else $error("ready pulled on port 70h");

  io_rdy_cause_a: assert property (
    $fell(ioChRdyOeN) |-> $past(ioStart) && $past(cfgReg[7:6]) != 2'h0)
    else $error("ready pulled without a core access");

  dma_min_low_a: assert property (
    dmaGo && toMemS && cfgReg[0] && cfgReg[5:4] == 2'h0 && !wideS
    |=> !dmaMemWrN [*2])
    else $error("minimum command low shorter than two periods");

  dma_min_end_a: assert property (
    (dmaGo && toMemS && cfgReg[0] && cfgReg[5:4] == 2'h0 && !wideS
     ##2 rdyS) |=> dmaMemWrN)
    else $error("command not released after its wait states");

  dma_slow_clk_a: assert property (
    dmaGo && toMemS && !cfgReg[0] && cfgReg[5:4] == 2'h0 && !wideS
    |=> !dmaMemWrN [*4])
    else $error("slow DMA clock not two bus clocks");

  dma_four_wait_a: assert property (
    dmaGo && !toMemS && cfgReg[0] && cfgReg[3:2] == 2'h3 && wideS
    |=> !dmaIoWrN [*5])
    else $error("16-bit code 11 low time too short");

  dma_field_sel_a: assert property (
    (dmaGo && !toMemS && cfgReg[0] && cfgReg[5:4] == 2'h1 && !wideS
     ##3 rdyS) |=> dmaIoWrN)
    else $error("8-bit transfer used the wrong wait field");

  dma_rdy_hold_a: assert property (
    !dmaMemWrN && !rdyS |=> !dmaMemWrN)
    else $error("command released while ready low");

  dma_memrd_lag_a: assert property (
    dmaGo && !toMemS && cfgReg[0] && !cfgReg[1]
    |=> dmaMemRdN && !dmaIoWrN ##1 !dmaMemRdN)
    else $error("memory read not delayed one period");

  dma_lag_slow_a: assert property (
    dmaGo && !toMemS && !cfgReg[0] && !cfgReg[1]
    |=> dmaMemRdN [*2] ##1 !dmaMemRdN)
    else $error("memory read not delayed two bus clocks");

  dma_memrd_now_a: assert property (
    dmaGo && !toMemS && cfgReg[1] |=> !dmaMemRdN && !dmaIoWrN)
    else $error("memory read delayed when not asked");

  dma_idle_high_a: assert property (
    !cfgIf.dmaBusy |-> dmaIoRdN && dmaIoWrN && dmaMemRdN && dmaMemWrN)
    else $error("DMA command low outside a cycle");

  // Main scenarios; the stretch window covers the longest stall used
  io_four_c: cover property (ioStart && ioIdle && cfgReg[7:6] == 2'h3);
  dma_stretch_c: cover property (!dmaMemWrN && !rdyS ##[1:40] dmaDone);
  dma_lag_c: cover property (dmaGo && !toMemS && !cfgReg[1]);
  // Slow DMA clock in use
  dma_slow_c: cover property (dmaGo && !cfgReg[0]);
  cfg_write_c: cover property (wrPendReg ##1 cfgReg == `AWC_CFG_TYP);
endmodule
`default_nettype wire

// ### verif/awc_at_agent.sv
`timescale 1ns/1ps
`default_nettype none
// AT bus agent: issues I/O and DMA cycles, shares the ready wire
module awc_at_agent (
  input  wire logic       clk,
  input  wire logic       ioChRdyOeN,
  input  wire logic       ioChRdyOut,
  output logic            ioCmdN,
  output logic [9:0]      portAddr,
  output logic            dmaReq,
  output logic            dmaWide,
  output logic            dmaToMem,
  output logic            ioChRdyIn
);
  logic stall = 1'b0; // Agent pulling the ready wire low

  // extra wait states
  // Wire has a pull-up, so it is high unless somebody pulls
  assign ioChRdyIn = !stall && !(!ioChRdyOeN && !ioChRdyOut);

  initial begin
    ioCmdN   = 1'b1;
    portAddr = 10'h3ff;
    dmaReq   = 1'b0;
    dmaWide  = 1'b0;
    dmaToMem = 1'b0;
  end

  // One I/O command; address set a cycle ahead so it is stable at the fall
  task automatic io_cycle(input logic [9:0] a);
    @(posedge clk);
    portAddr <= a;
    @(posedge clk);
    ioCmdN <= 1'b0;
    repeat (12) @(posedge clk);
    ioCmdN   <= 1'b1;
    portAddr <= ~a; // Released lines do not keep the old value
    repeat (3) @(posedge clk);
  endtask

  // stretch by pulling
  // One DMA request, held long enough for the slowest setting plus stall
  task automatic dma_cycle(input logic w, input logic m, input int st);
    @(posedge clk);
    dmaWide  <= w;
    dmaToMem <= m;
    dmaReq   <= 1'b1;
    // Stall only when asked, so the wire is assigned once per step
    if (st > 0) begin
      stall <= 1'b1;
      repeat (st) @(posedge clk);
    end
    stall <= 1'b0;
    repeat (40 - st) @(posedge clk);
    dmaReq   <= 1'b0;
    dmaWide  <= ~w;
    dmaToMem <= ~m;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### verif/awc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: register access over AHB-Lite, cycles through the AT agent
module awc_top_tb;
  import awc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp;
  logic        ioCmdN, dmaReq, dmaWide, dmaToMem, ioChRdyIn, ioChRdyOut, ioChRdyOeN;
  logic [9:0]  portAddr;
  logic        dmaIoRdN, dmaIoWrN, dmaMemRdN, dmaMemWrN, dmaDone;
  int          err_total = 0, tests_run = 0;
  int          ioLow = 0, wrLow = 0, rdLow = 0, mrLow = 0, doneCnt = 0;
  logic [10:0] ports [18] = '{11'h400, 11'h40f, 11'h010, 11'h420, 11'h423, 11'h024,
                             11'h440, 11'h443, 11'h070, 11'h471, 11'h48f, 11'h090,
                             11'h4a1, 11'h0a2, 11'h4c0, 11'h4df, 11'h0e0, 11'h120};
  // DMA corner settings: {control value, 2'h0, wide, toMem, write low clocks}
  logic [15:0] dmaCases [4] = '{16'h0112, 16'h0014, 16'h0d25, 16'h1f03};

  always #12.5 clk = ~clk;

  awc_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ioCmdN(ioCmdN),
    .portAddr(portAddr), .dmaReq(dmaReq), .dmaWide(dmaWide), .dmaToMem(dmaToMem),
    .ioChRdyIn(ioChRdyIn), .ioChRdyOut(ioChRdyOut), .ioChRdyOeN(ioChRdyOeN),
    .dmaIoRdN(dmaIoRdN), .dmaIoWrN(dmaIoWrN), .dmaMemRdN(dmaMemRdN),
    .dmaMemWrN(dmaMemWrN), .dmaDone(dmaDone));

  awc_at_agent agent (.clk(clk), .ioChRdyOeN(ioChRdyOeN), .ioChRdyOut(ioChRdyOut),
    .ioCmdN(ioCmdN), .portAddr(portAddr), .dmaReq(dmaReq), .dmaWide(dmaWide),
    .dmaToMem(dmaToMem), .ioChRdyIn(ioChRdyIn));

  // Free-running low-time counters; scenarios compare differences
  always @(posedge clk) begin
    if (ioChRdyOeN === 1'b0) ioLow <= ioLow + 1;
    if (dmaIoWrN === 1'b0 || dmaMemWrN === 1'b0) wrLow <= wrLow + 1;
    if (dmaIoRdN === 1'b0) rdLow <= rdLow + 1;
    if (dmaMemRdN === 1'b0) mrLow <= mrLow + 1;
    if (dmaDone === 1'b1) doneCnt <= doneCnt + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Waits for hready at an edge; a bound that runs out ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      stop_test();
    end
  endtask

  // Single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask

  initial begin
    int b, bw, br, bm, bd, per;
    logic [1:0] cc;
    logic wide;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    ahb(1'b0, 32'h4, 32'h0, rd);
    check("ctl reset", rd, 32'hc0);
    // Idle status: only the synced ready level is high
    ahb(1'b0, 32'h8, 32'h0, rd);
    check("status idle", rd, 32'h4);
    check("bus response", {31'h0, hresp}, 32'h0);
    check("ready drive level", {31'h0, ioChRdyOut}, 32'h0);
    ahb(1'b1, 32'h40, 32'hff, rd);
    ahb(1'b0, 32'h40, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    ahb(1'b1, 32'h4, 32'h0, rd);
    ahb(1'b0, 32'h4, 32'h0, rd);
    check("ctl typical", rd, 32'h0);
    for (int c = 0; c < 4; c++) begin
      cc = c[1:0];
      ahb(1'b1, 32'h4, {24'h0, cc, 6'h0}, rd);
      b = ioLow;
      agent.io_cycle(10'h020);
      check("io wait clocks", ioLow - b, (c == 3) ? 4 : c);
    end
    ahb(1'b1, 32'h4, 32'hc0, rd);
    for (int i = 0; i < 18; i++) begin
      b = ioLow;
      agent.io_cycle(ports[i][9:0]);
      check("port wait clocks", ioLow - b, ports[i][10] ? 4 : 0);
    end
    // DMA timing sweep; the unused field holds another code
    for (int c = 0; c < 4; c++) begin
      for (int f = 0; f < 2; f++) begin
        cc   = c[1:0];
        wide = cc[0] ^ f[0];
        per  = f ? 1 : 2;
        ahb(1'b1, 32'h4, {24'h0, 2'h0, wide ? ~cc : cc, wide ? cc : ~cc, cc[1], f[0]}, rd);
        bw = wrLow; br = rdLow; bm = mrLow; bd = doneCnt;
        agent.dma_cycle(wide, cc[0], 0);
        check("dma write low", wrLow - bw, (c + 2) * per);
        if (cc[0]) check("dma io read low", rdLow - br, (c + 2) * per);
        else check("dma mem read low", mrLow - bm, (c + 2) * per - (cc[1] ? 0 : per));
        check("dma done pulses", doneCnt - bd, 1);
      end
    end
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, 32'h4, {24'h0, dmaCases[i][15:8]}, rd);
      bw = wrLow;
      agent.dma_cycle(dmaCases[i][5], dmaCases[i][4], 0);
      check("dma corner low", wrLow - bw, {28'h0, dmaCases[i][3:0]});
    end
    ahb(1'b1, 32'h4, 32'h01, rd);
    bw = wrLow;
    agent.dma_cycle(1'b0, 1'b1, 12);
    // Ready held low twelve clocks keeps the command low twelve clocks
    check("dma stretched", wrLow - bw, 32'd12);
    stop_test();
  end

  // Watchdog against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
